/* src/ep_prioritizer.sv */
// Exception prioritizer: states, priorities, enables and entry sequencing.
// Functional notes
// RQ1 - Each exception inactive, pending, active or both.
// RQ2 - Request line or software makes interrupt pending.
// RQ3 - Handlers nest; several exceptions active together.
// RQ4 - Reset halts core; restart at reset vector.
// RQ5 - Stack pointer loaded from slot zero first.
// RQ6 - NMI from pin or software, fixed rank.
// RQ7 - Hard fault on entry error or escalation.
// RQ8 - Programmable level zero ranks fourth; resets zero.
// RQ9 - Eight levels for system exceptions and interrupts.
// RQ10 - Group field alone decides preemption.
// RQ11 - Memory fault on violation or execute-never fetch.
// RQ12 - Bus fault enableable, precise or imprecise.
// RQ13 - Usage fault causes, optional unaligned and divide.
// RQ14 - Supervisor call instruction raises slot eleven.
// RQ15 - Debug monitor needs enable and sufficient priority.
// RQ16 - Pendable service raised by software only.
// RQ17 - System tick from timer or software.
// RQ18 - Interrupt n sits at vector n plus sixteen.
// RQ19 - Disabled configurable exceptions are never taken.
// RQ20 - Vector fetch runs alongside state saving.
// RQ21 - Tail-chain to pending exception without restore.
// RQ22 - Asynchronous entry may lag one instruction.
// RQ23 - Handlers should clear their sources early.
// RQ24 - Equal priority: lowest exception number first.
// RQ25 - Equal priority never preempts, only pends.
// RQ26 - Configurable priority fields hold zero to seven.
// RQ27 - Activation clears pending; new request sets again.
// RQ28 - Reserved slots never raised; read as zero.
module ep_prioritizer
    import ep_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        NMI_PIN,
    input  wire logic [43:0] IRQ_LINES,
    input  wire logic        SYSTICK_ZERO,
    input  wire logic        FAULT_MEM,
    input  wire logic        FAULT_XN_FETCH,
    input  wire logic        FAULT_BUS_PRECISE,
    input  wire logic        FAULT_BUS_IMPRECISE,
    input  wire logic        FAULT_UNDEF,
    input  wire logic        FAULT_UNALIGN_ILLEGAL,
    input  wire logic        FAULT_STATE,
    input  wire logic        FAULT_EXC_RETURN,
    input  wire logic        FAULT_UNALIGN,
    input  wire logic        FAULT_DIV0,
    input  wire logic        ENTRY_ERROR,
    input  wire logic        SVC_EXEC,
    input  wire logic        DEBUG_MON_REQ,
    input  wire logic        CORE_ACK,
    input  wire logic        CORE_EXIT,
    input  wire logic [5:0]  CORE_EXIT_VEC,
    output logic             CORE_HOLD,
    output logic             ENTRY_REQ,
    output logic      [5:0]  ENTRY_VEC,
    output logic      [31:0] ENTRY_ADDR,
    output logic             ENTRY_STACK,
    output logic             UNSTACK,
    output logic             THREAD_MODE
);
    ////////////////////////////////////////////////////////////////////////////
    ep_state_type     state_q,    state_d;
    logic [5:0]       vec_q,      vec_d;
    logic             stack_q,    stack_d;
    logic             unstack_q,  unstack_d;
    logic [63:0]      pend_q,     pend_d;
    logic [63:0]      act_q,      act_d;
    logic [63:0][2:0] pri_q,      pri_d;
    logic [43:0]      irq_en_q,   irq_en_d;
    logic [9:0]       shc_q;
    logic [31:0]      prdata_q;
    logic             nmi_sync;
    logic [63:0]      en_v;
    logic [63:0]      set_v;
    logic [63:0]      clr_v;
    logic [63:0]      pre_v;
    logic [63:0][3:0] rank_full;
    logic [63:0][3:0] rank_grp;
    logic [3:0]       exec_rank;
    logic [5:0]       act_top;
    logic [1:0]       split;
    logic             take;
    logic             ack_e;
    logic [31:0]      rdata;
    logic             map_ok;
    logic [31:0]      pri_rd;
    logic             tie_viol;

    ep_pick_if pk ();

    ep_pick u_pick (
        .bus (pk)
    );

    ep_sync u_nmi_sync (
        .CLOCK (CLOCK),
        .RST_N (RST_N),
        .D     (NMI_PIN),
        .Q     (nmi_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode. The slave never waits, so every access is two cycles.
    wire        wr      = PSEL && PENABLE && PWRITE;
    wire        w_ctrl  = wr && (PADDR == EP_OFF_CTRL);
    wire        w_shc   = wr && (PADDR == EP_OFF_SHC);
    wire        w_spri  = wr && (PADDR == EP_OFF_SPRI);
    wire        w_ens0  = wr && (PADDR == EP_OFF_ENS0);
    wire        w_ens1  = wr && (PADDR == EP_OFF_ENS1);
    wire        w_enc0  = wr && (PADDR == EP_OFF_ENC0);
    wire        w_enc1  = wr && (PADDR == EP_OFF_ENC1);
    wire        w_pns0  = wr && (PADDR == EP_OFF_PNS0);
    wire        w_pns1  = wr && (PADDR == EP_OFF_PNS1);
    wire        w_pnc0  = wr && (PADDR == EP_OFF_PNC0);
    wire        w_pnc1  = wr && (PADDR == EP_OFF_PNC1);
    wire        pri_hit = (PADDR[7:5] == EP_OFF_PRI_HI) && (PADDR[4:2] < EP_PRI_WORDS) && (PADDR[1:0] == 2'b00);
    wire        w_pri   = wr && pri_hit;
    wire [43:0] en_set  = {w_ens1 ? PWDATA[11:0] : 12'h000, w_ens0 ? PWDATA : 32'h0};
    wire [43:0] en_clr  = {w_enc1 ? PWDATA[11:0] : 12'h000, w_enc0 ? PWDATA : 32'h0};
    wire [43:0] sw_pset = {w_pns1 ? PWDATA[11:0] : 12'h000, w_pns0 ? PWDATA : 32'h0};
    wire [43:0] sw_pclr = {w_pnc1 ? PWDATA[11:0] : 12'h000, w_pnc0 ? PWDATA : 32'h0};

    assign split = shc_q[9:8];
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = PSEL && PENABLE && !map_ok;

    always_comb begin
        pri_rd = 32'h0;
        for (int k = 0; k < 8; k++) begin
            if (32'(PADDR[4:2]) * 8 + k < EP_NIRQ) begin
                pri_rd[4*k +: 3] = pri_q[16 + 32'(PADDR[4:2]) * 8 + k];
            end
        end
    end

    always_comb begin
        rdata  = 32'h0;
        map_ok = 1'b1;
        if (pri_hit) begin
            rdata = pri_rd;
        end else begin
            unique case (PADDR)
                EP_OFF_CTRL: rdata = {9'h0, pk.found, 4'h0, pk.best_vec, 6'h0, act_top};
                EP_OFF_SHC:  rdata = {22'h0, shc_q};
                EP_OFF_SPRI: begin
                    for (int j = 0; j < 7; j++) begin
                        rdata[4*j +: 3] = pri_q[EP_SYS_VEC[j]];
                    end
                end
                EP_OFF_ENS0, EP_OFF_ENC0: rdata = irq_en_q[31:0];
                EP_OFF_ENS1, EP_OFF_ENC1: rdata = {20'h0, irq_en_q[43:32]};
                EP_OFF_PNS0, EP_OFF_PNC0: rdata = pend_q[47:16];
                EP_OFF_PNS1, EP_OFF_PNC1: rdata = {20'h0, pend_q[59:48]};
                EP_OFF_ACT0: rdata = act_q[47:16];
                EP_OFF_ACT1: rdata = {20'h0, act_q[59:48]};
                default:     map_ok = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RQ19 enables per vector.
    assign en_v = {4'h0, irq_en_q, 1'b1, 1'b1, 1'b0, shc_q[3], 1'b1, 4'h0,
                   shc_q[2], shc_q[1], shc_q[0], 1'b1, 1'b1, 2'b00};

    // RQ10 group ranks for preemption.
    always_comb begin
        exec_rank = EP_RANK_THREAD;
        act_top   = 6'h00;
        for (int v = 0; v < 64; v++) begin
            rank_full[v] = ep_rank(6'(v), pri_q[v], split, 1'b0);
            rank_grp[v]  = ep_rank(6'(v), pri_q[v], split, 1'b1);
            // RQ3 nested handlers.
            if (act_q[v] && rank_grp[v] < exec_rank) begin
                exec_rank = rank_grp[v];
                act_top   = 6'(v);
            end
        end
        for (int v = 0; v < 64; v++) begin
            pre_v[v] = rank_grp[v] < exec_rank;
        end
    end

    // RQ22 entry from registered pending.
    assign pk.cand = pend_q & en_v;
    assign pk.rank = rank_full;
    // RQ25 strict group comparison.
    assign take = pk.found && (rank_grp[pk.best_vec] < exec_rank);

    ////////////////////////////////////////////////////////////////////////////
    // Fault sources. Synchronous faults that cannot run now escalate.
    wire mem_raw = FAULT_MEM || FAULT_XN_FETCH;
    // RQ13 usage fault causes.
    wire use_raw = FAULT_UNDEF || FAULT_UNALIGN_ILLEGAL || FAULT_STATE || FAULT_EXC_RETURN
                   || (FAULT_UNALIGN && shc_q[4]) || (FAULT_DIV0 && shc_q[5]);
    // RQ11 memory fault raise.
    wire mem_ok  = en_v[EP_V_MEM] && pre_v[EP_V_MEM];
    wire use_ok  = en_v[EP_V_USAGE] && pre_v[EP_V_USAGE];
    // RQ14 supervisor call raise.
    wire svc_ok  = pre_v[EP_V_SVC];
    // RQ12 precise and imprecise bus faults.
    wire bus_set = (FAULT_BUS_PRECISE && en_v[EP_V_BUS] && pre_v[EP_V_BUS])
                   || (FAULT_BUS_IMPRECISE && en_v[EP_V_BUS]);
    wire bus_esc = (FAULT_BUS_PRECISE && !(en_v[EP_V_BUS] && pre_v[EP_V_BUS]))
                   || (FAULT_BUS_IMPRECISE && !en_v[EP_V_BUS]);
    // RQ7 hard fault escalation.
    wire hard_set = ENTRY_ERROR || bus_esc || (mem_raw && !mem_ok) || (use_raw && !use_ok)
                    || (SVC_EXEC && !svc_ok);
    // RQ15 debug monitor gating.
    wire dbg_set = DEBUG_MON_REQ && en_v[EP_V_DBG] && pre_v[EP_V_DBG];
    // RQ6 NMI triggers.
    wire nmi_set = nmi_sync || (w_ctrl && PWDATA[EP_B_NMI_SET]);
    // RQ16 software-only pendable service.
    wire psv_set = w_ctrl && PWDATA[EP_B_PSV_SET];
    // RQ17 tick from timer or software.
    wire tck_set = SYSTICK_ZERO || (w_ctrl && PWDATA[EP_B_TCK_SET]);
    wire psv_clr = w_ctrl && PWDATA[EP_B_PSV_CLR];
    wire tck_clr = w_ctrl && PWDATA[EP_B_TCK_CLR];
    // RQ2 line or software request.
    wire [43:0] irq_set = IRQ_LINES | sw_pset;

    assign ack_e = CORE_ACK && (state_q == EP_S_ENTRY);

    // RQ18 interrupt n at vector n plus sixteen.
    assign set_v = {4'h0, irq_set, tck_set, psv_set, 1'b0, dbg_set, SVC_EXEC && svc_ok, 4'h0,
                    use_raw && use_ok, bus_set, mem_raw && mem_ok, hard_set, nmi_set, 2'b00};
    // RQ27 activation clears pending.
    assign clr_v = {4'h0, sw_pclr, tck_clr, psv_clr, 14'h0} | (ack_e ? (64'h1 << vec_q) : 64'h0);
    // RQ1 set wins over clear.
    // RQ28 reserved slots never raised.
    assign pend_d = ((pend_q & ~clr_v) | set_v) & {4'h0, EP_IRQ_IMPL, EP_SYS_RAISE};

    always_comb begin
        act_d = act_q;
        if (ack_e) begin
            act_d[vec_q] = 1'b1;
        end
        if (CORE_EXIT && state_q == EP_S_RUN) begin
            act_d[CORE_EXIT_VEC] = 1'b0;
        end
    end

    // RQ26 three-bit fields only.
    // RQ9 writable levels.
    always_comb begin
        pri_d = pri_q;
        for (int i = 0; i < EP_NIRQ; i++) begin
            if (w_pri && EP_IRQ_IMPL[i] && PADDR[4:2] == 3'(i / 8)) begin
                pri_d[16 + i] = PWDATA[4 * (i % 8) +: 3];
            end
        end
        for (int j = 0; j < 7; j++) begin
            if (w_spri) begin
                pri_d[EP_SYS_VEC[j]] = PWDATA[4*j +: 3];
            end
        end
    end

    assign irq_en_d = (irq_en_q | en_set) & ~en_clr & EP_IRQ_IMPL;

    ////////////////////////////////////////////////////////////////////////////
    // Entry sequencer. A better request may replace the one waiting for ack.
    always_comb begin
        state_d   = state_q;
        vec_d     = vec_q;
        stack_d   = stack_q;
        unstack_d = 1'b0;
        unique case (state_q)
            // RQ5 stack pointer first.
            EP_S_SP: begin
                if (CORE_ACK) begin
                    vec_d   = EP_V_RESET;
                    state_d = EP_S_PC;
                end
            end
            // RQ4 restart at reset vector.
            EP_S_PC: begin
                if (CORE_ACK) begin
                    state_d = EP_S_RUN;
                end
            end
            EP_S_RUN: begin
                if (CORE_EXIT) begin
                    state_d = EP_S_EXIT;
                end else if (take) begin
                    vec_d   = pk.best_vec;
                    stack_d = 1'b1;
                    state_d = EP_S_ENTRY;
                end
            end
            // RQ20 vector fetch with stacking.
            EP_S_ENTRY: begin
                if (CORE_ACK) begin
                    state_d = EP_S_RUN;
                end else if (take && pk.best_vec != vec_q) begin
                    vec_d = pk.best_vec;
                end
            end
            // RQ21 tail-chain.
            EP_S_EXIT: begin
                if (take) begin
                    vec_d   = pk.best_vec;
                    stack_d = 1'b0;
                    state_d = EP_S_ENTRY;
                end else begin
                    unstack_d = 1'b1;
                    state_d   = EP_S_RUN;
                end
            end
            default: state_d = EP_S_SP;
        endcase
    end

    // RQ8 priorities reset to zero.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q   <= EP_S_SP;
            vec_q     <= EP_V_SP;
            stack_q   <= 1'b0;
            unstack_q <= 1'b0;
            pend_q    <= 64'h0;
            act_q     <= 64'h0;
            pri_q     <= {64{EP_PRI_RESET}};
            irq_en_q  <= 44'h0;
            shc_q     <= EP_SHC_RESET;
            prdata_q  <= 32'h0;
        end else begin
            state_q   <= state_d;
            vec_q     <= vec_d;
            stack_q   <= stack_d;
            unstack_q <= unstack_d;
            pend_q    <= pend_d;
            act_q     <= act_d;
            pri_q     <= pri_d;
            irq_en_q  <= irq_en_d;
            shc_q     <= w_shc ? (PWDATA[9:0] & EP_SHC_MASK) : shc_q;
            prdata_q  <= (PSEL && !PENABLE && !PWRITE) ? rdata : prdata_q;
        end
    end

    // RQ4 halt during reset and boot fetches.
    assign CORE_HOLD   = !RST_N || state_q == EP_S_SP || state_q == EP_S_PC;
    assign ENTRY_REQ   = state_q == EP_S_SP || state_q == EP_S_PC || state_q == EP_S_ENTRY;
    assign ENTRY_VEC   = vec_q;
    assign ENTRY_ADDR  = {24'h0, vec_q, 2'b00};
    assign ENTRY_STACK = stack_q;
    assign UNSTACK     = unstack_q;
    assign THREAD_MODE = act_q == 64'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks. The tie helper is only read by an assertion.
    always_comb begin
        tie_viol = 1'b0;
        for (int v = 0; v < 64; v++) begin
            if (pk.found && pk.cand[v] && 6'(v) < pk.best_vec && pk.rank[v] <= pk.best_rank) begin
                tie_viol = 1'b1;
            end
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_irq_to_pend: assert property (IRQ_LINES[0] |=> pend_q[16]) // RQ2
        else $error("Interrupt line did not pend.");
    a_nmi_to_pend: assert property (nmi_sync |=> pend_q[EP_V_NMI]) // RQ6
        else $error("NMI did not pend.");
    a_reserved_idle: assert property (((pend_q | act_q) & ~{4'h0, EP_IRQ_IMPL, EP_SYS_RAISE}) == 64'h0) // RQ28
        else $error("Reserved slot raised.");
    a_ack_clears: assert property ((ack_e && !set_v[vec_q]) |=> act_q[$past(vec_q)] && !pend_q[$past(vec_q)]) // RQ27
        else $error("Activation did not move pending to active.");
    a_boot_sp_pc: assert property ((state_q == EP_S_SP && CORE_ACK) |=> ENTRY_REQ && ENTRY_ADDR == 32'h4) // RQ5
        else $error("Reset vector fetch did not follow stack load.");
    a_boot_hold: assert property ($rose(RST_N) |-> CORE_HOLD && ENTRY_ADDR == 32'h0) // RQ4
        else $error("Boot did not start at slot zero.");
    a_entry_preempts: assert property (state_q == EP_S_ENTRY |-> rank_grp[vec_q] < exec_rank) // RQ25
        else $error("Entry without higher group priority.");
    a_entry_enabled: assert property (state_q == EP_S_ENTRY |-> en_v[vec_q]) // RQ19
        else $error("Disabled exception taken.");
    a_tie_lowest: assert property (!tie_viol) // RQ24
        else $error("Tie not resolved to lowest number.");
    a_tail_chain: assert property ((state_q == EP_S_EXIT && take) |=> ENTRY_REQ && !ENTRY_STACK && !UNSTACK) // RQ21
        else $error("Tail-chain restored state.");
    a_usage_escal: assert property ((FAULT_UNDEF && !en_v[EP_V_USAGE]) |=> pend_q[EP_V_HARD]) // RQ7
        else $error("Disabled usage fault did not escalate.");
endmodule

/* include/ep_pkg.sv */
// Constants, types and rank helper shared by the exception prioritizer.
package ep_pkg;
    localparam int          EP_NVEC   = 64;
    localparam int          EP_NIRQ   = 44;
    localparam logic [43:0] EP_IRQ_IMPL  = 44'h400f7fc00bf;
    localparam logic [15:0] EP_SYS_RAISE = 16'hd87c;
    localparam logic [5:0]  EP_V_SP      = 6'h00;
    localparam logic [5:0]  EP_V_RESET   = 6'h01;
    localparam logic [5:0]  EP_V_NMI     = 6'h02;
    localparam logic [5:0]  EP_V_HARD    = 6'h03;
    localparam logic [5:0]  EP_V_MEM     = 6'h04;
    localparam logic [5:0]  EP_V_BUS     = 6'h05;
    localparam logic [5:0]  EP_V_USAGE   = 6'h06;
    localparam logic [5:0]  EP_V_SVC     = 6'h0b;
    localparam logic [5:0]  EP_V_DBG     = 6'h0c;
    localparam logic [5:0]  EP_V_PENDABLE_SERVICE_EXCEPTION  = 6'h0e;
    localparam logic [5:0]  EP_V_TICK    = 6'h0f;
    localparam logic [5:0]  EP_SYS_VEC [7] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e, 6'h0f};
    localparam logic [3:0]  EP_RANK_THREAD = 4'hf;
    localparam logic [2:0]  EP_PRI_RESET   = 3'h0;
    // Register byte offsets.
    localparam logic [7:0]  EP_OFF_CTRL  = 8'h00;
    localparam logic [7:0]  EP_OFF_SHC   = 8'h04;
    localparam logic [7:0]  EP_OFF_SPRI  = 8'h08;
    localparam logic [7:0]  EP_OFF_ENS0  = 8'h10;
    localparam logic [7:0]  EP_OFF_ENS1  = 8'h14;
    localparam logic [7:0]  EP_OFF_ENC0  = 8'h18;
    localparam logic [7:0]  EP_OFF_ENC1  = 8'h1c;
    localparam logic [7:0]  EP_OFF_PNS0  = 8'h20;
    localparam logic [7:0]  EP_OFF_PNS1  = 8'h24;
    localparam logic [7:0]  EP_OFF_PNC0  = 8'h28;
    localparam logic [7:0]  EP_OFF_PNC1  = 8'h2c;
    localparam logic [7:0]  EP_OFF_ACT0  = 8'h30;
    localparam logic [7:0]  EP_OFF_ACT1  = 8'h34;
    localparam logic [2:0]  EP_OFF_PRI_HI = 3'h2;
    localparam logic [2:0]  EP_PRI_WORDS  = 3'h6;
    // Control word fields, then the handler control write mask and reset value.
    localparam int          EP_B_NMI_SET = 31;
    localparam int          EP_B_PSV_SET = 28;
    localparam int          EP_B_PSV_CLR = 27;
    localparam int          EP_B_TCK_SET = 26;
    localparam int          EP_B_TCK_CLR = 25;
    localparam int          EP_B_ANY_PND = 22;
    localparam int          EP_B_PND_VEC = 12;
    localparam logic [9:0]  EP_SHC_MASK  = 10'h33f;
    localparam logic [9:0]  EP_SHC_RESET = 10'h000;

    typedef enum logic [2:0] {
        EP_S_SP    = 3'b000,
        EP_S_PC    = 3'b001,
        EP_S_RUN   = 3'b010,
        EP_S_ENTRY = 3'b011,
        EP_S_EXIT  = 3'b100
    } ep_state_type;

    // Lower rank wins; group form drops the subpriority bits.
    function automatic logic [3:0] ep_rank(input logic [5:0] v, input logic [2:0] p,
                                           input logic [1:0] split, input logic grp);
        logic [2:0] g;
        g = grp ? (p & (3'h7 << split)) : p;
        if (v == EP_V_NMI) begin
            return 4'h0;
        end
        if (v == EP_V_HARD) begin
            return 4'h1;
        end
        return 4'h2 + {1'b0, g};
    endfunction
endpackage

/* include/ep_pick_if.sv */
// Candidate and winner signals between the prioritizer and its picker.
interface ep_pick_if;
    logic [63:0]      cand;
    logic [63:0][3:0] rank;
    logic [5:0]       best_vec;
    logic [3:0]       best_rank;
    logic             found;
    modport req  (output cand, rank, input best_vec, best_rank, found);
    modport pick (input cand, rank, output best_vec, best_rank, found);
endinterface

/* src/ep_sync.sv */
// Two-stage synchronizer for a level arriving from a pin.
module ep_sync (
    input  wire logic CLOCK,
    input  wire logic RST_N,
    input  wire logic D,
    output logic      Q
);
    logic meta_q;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            meta_q <= 1'b0;
            Q      <= 1'b0;
        end else begin
            meta_q <= D;
            Q      <= meta_q;
        end
    end
endmodule

/* src/ep_pick.sv */
// Picks the best pending candidate: lowest rank, then lowest number.
module ep_pick (
    ep_pick_if.pick bus
);
    always_comb begin
        bus.found     = 1'b0;
        bus.best_vec  = 6'h00;
        bus.best_rank = 4'hf;
        // RQ24 ties to lowest number.
        for (int v = 0; v < 64; v++) begin
            if (bus.cand[v] && (!bus.found || bus.rank[v] < bus.best_rank)) begin
                bus.found     = 1'b1;
                bus.best_vec  = 6'(v);
                bus.best_rank = bus.rank[v];
            end
        end
    end
endmodule

/* bench/ep_core_model.sv */
// Behavioural core model: takes vector fetches and logs each one.
module ep_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic [5:0]  vec,
    input  wire logic [31:0] addr,
    input  wire logic        stack,
    output logic             ack
);
    timeunit 1ns / 1ns;
    int unsigned wait_cyc = 1;
    int unsigned cnt;
    logic [15:0] log_q [$];
    ////////////////////////////////////////
    // The vector may still move to a later winner, so it is logged at the ack edge.
    always @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
            cnt <= 0;
        end else if (ack) begin
            log_q.push_back({|addr[31:8], addr[7:0], stack, vec});
            ack <= 1'b0;
            cnt <= 0;
        end else if (req && cnt >= wait_cyc) begin
            ack <= 1'b1;
        end else begin
            cnt <= req ? cnt + 1 : 0;
        end
    end
endmodule

/* bench/exception_prioritizer_test.sv */
// Self-checking bench for the exception prioritizer.
module exception_prioritizer_test
    import ep_pkg::*;
;
    timeunit 1ns / 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cexit = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, eaddr;
    logic [43:0] irq = 44'h0;
    logic [14:0] ev = 15'h0;
    logic [5:0]  xvec = 6'h00, evec;
    logic        pready, pslverr, hold, ereq, estack, unstack, thread, ack, serr, uns;
    int          err_count = 0, num_checks = 0;
    localparam logic [5:0] EXP_V [15] = '{EP_V_MEM, EP_V_MEM, EP_V_BUS, EP_V_BUS, EP_V_USAGE, EP_V_USAGE,
        EP_V_USAGE, EP_V_USAGE, EP_V_USAGE, EP_V_USAGE, EP_V_HARD, EP_V_SVC, EP_V_DBG, EP_V_TICK, EP_V_NMI};
    always #20 clk = ~clk;
    ep_prioritizer dut_u (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NMI_PIN(ev[14]),
        .IRQ_LINES(irq), .SYSTICK_ZERO(ev[13]), .FAULT_MEM(ev[0]), .FAULT_XN_FETCH(ev[1]),
        .FAULT_BUS_PRECISE(ev[2]), .FAULT_BUS_IMPRECISE(ev[3]), .FAULT_UNDEF(ev[4]),
        .FAULT_UNALIGN_ILLEGAL(ev[5]), .FAULT_STATE(ev[6]), .FAULT_EXC_RETURN(ev[7]), .FAULT_UNALIGN(ev[8]),
        .FAULT_DIV0(ev[9]), .ENTRY_ERROR(ev[10]), .SVC_EXEC(ev[11]), .DEBUG_MON_REQ(ev[12]), .CORE_ACK(ack),
        .CORE_EXIT(cexit), .CORE_EXIT_VEC(xvec), .CORE_HOLD(hold), .ENTRY_REQ(ereq), .ENTRY_VEC(evec),
        .ENTRY_ADDR(eaddr), .ENTRY_STACK(estack), .UNSTACK(unstack), .THREAD_MODE(thread));
    ep_core_model core_u (.clk(clk), .rst_n(rst_n), .req(ereq), .vec(evec), .addr(eaddr), .stack(estack),
        .ack(ack));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Zero wait states today; the master polls for ready but counts any wait as an error.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 1);
        if (n >= 20) begin
            tally_and_finish();
        end
    endtask
    task automatic entered(input int k, input logic s, input logic [5:0] v);
        int n;
        n = 0;
        while (core_u.log_q.size() < k && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n >= 60) begin
            chk(0, 1);
            tally_and_finish();
        end
        chk({16'h0, core_u.log_q[k-1]}, {16'h0, 1'b0, v, 2'b00, s, v});
    endtask
    task automatic leave(input logic [5:0] v);
        @(posedge clk);
        cexit <= 1'b1;
        xvec <= v;
        @(posedge clk);
        cexit <= 1'b0;
        uns = 1'b0;
        repeat (5) begin
            @(negedge clk);
            uns = uns | unstack;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        entered(1, 1'b0, EP_V_SP);
        entered(2, 1'b0, EP_V_RESET);
        repeat (3) @(negedge clk);
        chk({hold, thread}, 32'h1);
        apb(1'b0, EP_OFF_SPRI, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, EP_OFF_SPRI, 32'hffffffff);
        apb(1'b0, EP_OFF_SPRI, 32'h0);
        chk(rd, 32'h07777777);
        apb(1'b1, EP_OFF_SPRI, 32'h0);
        apb(1'b1, 8'h40, 32'hffffffff);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h70777777);
        apb(1'b1, 8'h40, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk({rd[31:1], serr}, 32'h1);
        apb(1'b1, EP_OFF_ENS0, 32'h3);
        apb(1'b1, EP_OFF_PNS0, 32'h3);
        entered(3, 1'b1, 6'h10);
        irq[0] <= 1'b1;
        apb(1'b0, EP_OFF_ACT0, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, EP_OFF_PNC0, 32'h0);
        chk(rd, 32'h3);
        irq[0] <= 1'b0;
        apb(1'b1, EP_OFF_PNC0, 32'h1);
        core_u.wait_cyc = 4;
        apb(1'b1, EP_OFF_CTRL, 32'h80000000);
        entered(4, 1'b1, EP_V_NMI);
        apb(1'b0, EP_OFF_ACT0, 32'h0);
        chk(rd, 32'h1);
        leave(EP_V_NMI);
        chk({uns, 5'(core_u.log_q.size())}, 32'h24);
        leave(6'h10);
        entered(5, 1'b0, 6'h11);
        leave(6'h11);
        chk({uns, thread}, 32'h3);
        apb(1'b1, EP_OFF_PNS0, 32'h4);
        apb(1'b0, EP_OFF_CTRL, 32'h0);
        chk({rd[EP_B_ANY_PND], 5'(core_u.log_q.size())}, 32'h5);
        apb(1'b1, EP_OFF_SHC, 32'h3f);
        foreach (EXP_V[i]) begin
            @(posedge clk);
            ev[i] <= 1'b1;
            @(posedge clk);
            ev[i] <= 1'b0;
            entered(6 + i, 1'b1, EXP_V[i]);
            leave(EXP_V[i]);
        end
        apb(1'b1, EP_OFF_SHC, 32'h0);
        ev[4] <= 1'b1;
        @(posedge clk);
        ev[4] <= 1'b0;
        entered(21, 1'b1, EP_V_HARD);
        leave(EP_V_HARD);
        apb(1'b1, EP_OFF_CTRL, 32'h10000000);
        entered(22, 1'b1, EP_V_PENDABLE_SERVICE_EXCEPTION);
        leave(EP_V_PENDABLE_SERVICE_EXCEPTION);
        apb(1'b1, EP_OFF_SHC, 32'h100);
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b1, EP_OFF_PNS0, 32'h1);
        entered(23, 1'b1, 6'h10);
        apb(1'b1, EP_OFF_PNS0, 32'h2);
        repeat (8) @(posedge clk);
        apb(1'b0, EP_OFF_PNC0, 32'h0);
        chk({rd[1:0], 5'(core_u.log_q.size())}, 32'h57);
        tally_and_finish();
    end
endmodule
